/* File: fcc_pkg.sv */
// Shared constants for the flash charger control ends.
// Assumes one 200 MHz clock shared by both ends.
package fcc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned SETUP_WINDOW_NS = 200000;
    localparam int unsigned OFF_MAX_NS      = 18000;
    localparam int unsigned FIRST_PULSE_NS  = 15000;
    localparam int unsigned SHORT_PULSE_NS  = 200;
    localparam int unsigned TRIGGER_IN_PULSE_NS   = 1000;
    // Longest times round down, least times round up
    localparam int unsigned SETUP_WINDOW_CYC = SETUP_WINDOW_NS / CLK_PERIOD_NS;
    localparam int unsigned OFF_MAX_CYC      = OFF_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned FIRST_PULSE_CYC  = (FIRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHORT_PULSE_CYC  = (SHORT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TRIGGER_IN_PULSE_CYC   = (TRIGGER_IN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Current limit coding
    // ------------------------------------------------------------
    localparam int unsigned LIMIT_W          = 4;
    localparam logic [3:0]  LIMIT_DEFAULT    = 4'h0;   // Full scale, 1.5 A
    localparam logic [3:0]  LIMIT_LOWEST     = 4'hf;   // 29 % of full scale
    localparam int unsigned TIMER_W          = 16;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_SETUP   = 3'b001,
        ST_ON      = 3'b010,
        ST_OFF     = 3'b011,
        ST_DONE    = 3'b100,
        ST_LOCKED  = 3'b101
    } fcc_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE    = 3'b000,
        HS_LOW     = 3'b001,
        HS_FIRST   = 3'b010,
        HS_GAPLOW  = 3'b011,
        HS_GAPHIGH = 3'b100,
        HS_HOLD    = 3'b101
    } fcc_host_state_t;

endpackage

/* File: fcc_link_if.sv */
// Pin-level link between the host controller and the charger.
// The done line is open drain with an assumed pull-up.
interface fcc_link_if;
    logic chargeRequest;
    logic trigger;
    logic doneOut;
    logic doneOeN;
    logic doneLine;

    // Pull-up wins while nobody pulls low
    assign doneLine = doneOeN ? 1'b1 : doneOut;

    modport dev (
        input  chargeRequest,
        input  trigger,
        output doneOut,
        output doneOeN
    );
    modport hst (
        output chargeRequest,
        output trigger,
        input  doneLine
    );
endinterface

/* File: fcc_device.sv */
// Charger end: charge sequencing, limit decoder, gate driver, done flag.
// Assumes analog comparators arrive as levels on sys_clk; link pins are async.
//
// Notes on behaviour
// - Charge starts on request rise above lockout
// - Rise under lockout ignored; needs fresh rise
// - Stop at target; new rise for recharge
// - Request low keeps standby, switching off
// - Gate drive follows trigger always
// - Host avoids triggers while charging
// - Host holds request low at power-up
// - Done pulled low: request high and target
// - Default limit is full scale, 15 steps
// - Switch off at selected peak current
// - Next cycle: flux reset or 18 us
// - Low output: fixed 18 us timer mode
// - Fast mode waits secondary end, valley
// - Sixteen levels, 100 to 29 percent
// - Switching begins after setup window ends
// - Limit held while high; low resets decoder
// - First rise starts decoder, counts 16 edges
// - Host first pulse at least 15 us
// - Host later pulses down to 0.2 us
// - Host last edge within 200 us
// - Each extra pulse lowers limit one level
module fcc_device
    import fcc_pkg::*;
#(
    parameter int unsigned SETUP_CYC = fcc_pkg::SETUP_WINDOW_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    fcc_link_if.dev                link,
    input  wire logic              supplyOk,
    input  wire logic              peakReached,
    input  wire logic              fluxReset,
    input  wire logic              fastModeOk,
    input  wire logic              targetReached,
    output logic                   switchOn,
    output logic                   gateDrive,
    output logic                   timerMode,
    output logic                   charging,
    output logic [fcc_pkg::LIMIT_W-1:0] currentLimitCode
);
    import fcc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0]           pinSync0_r;
    logic [1:0]           pinSync1_r;
    logic [1:0]           pinSync2_r;
    logic [1:0]           pinFilt_r;
    logic                 chargeHigh;
    logic                 trigHigh;
    logic                 chargePrev_r;
    logic                 chargeRise;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pinSync0_r <= 2'h0;
            pinSync1_r <= 2'h0;
            pinSync2_r <= 2'h0;
        end else begin
            pinSync0_r <= {link.trigger, link.chargeRequest};
            pinSync1_r <= pinSync0_r;
            pinSync2_r <= pinSync1_r;
        end
    end

    // A change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gFilt
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    pinFilt_r[gi] <= 1'b0;
                end else if (pinSync1_r[gi] == pinSync2_r[gi]) begin
                    pinFilt_r[gi] <= pinSync2_r[gi];
                end
            end
        end
    endgenerate

    assign chargeHigh = pinFilt_r[0];
    assign trigHigh   = pinFilt_r[1];
    assign chargeRise = chargeHigh & ~chargePrev_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chargePrev_r <= 1'b0;
        end else begin
            chargePrev_r <= chargeHigh;
        end
    end

    // ------------------------------------------------------------
    // Charge sequencer and limit decoder
    // ------------------------------------------------------------
    fcc_dev_state_t       state_r;
    fcc_dev_state_t       state_nxt;
    logic [TIMER_W-1:0]   timer_r;
    logic [LIMIT_W-1:0]   edgeCnt_r;
    logic                 windowEnd;
    logic                 offTimeout;
    logic                 restart;

    assign windowEnd  = (timer_r == TIMER_W'(SETUP_CYC - 1));
    assign offTimeout = (timer_r == TIMER_W'(OFF_MAX_CYC - 1));
    // Timer mode ignores flux reset, fast mode takes the earlier event
    assign restart    = offTimeout | (fastModeOk & fluxReset);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_STANDBY: begin
                if (chargeRise) begin
                    state_nxt = supplyOk ? ST_SETUP : ST_LOCKED;
                end
            end
            ST_SETUP: begin
                // Low gaps inside the window are programming pulses
                if (windowEnd) begin
                    if (!chargeHigh) begin
                        state_nxt = ST_STANDBY;
                    end else if (!supplyOk) begin
                        state_nxt = ST_LOCKED;
                    end else begin
                        state_nxt = ST_ON;
                    end
                end
            end
            ST_ON: begin
                if (peakReached || offTimeout) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_OFF: begin
                // Output is sensed while the switch is off
                if (targetReached) begin
                    state_nxt = ST_DONE;
                end else if (restart) begin
                    state_nxt = ST_ON;
                end
            end
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
            ST_LOCKED: begin
                state_nxt = ST_LOCKED;
            end
            default: begin
                state_nxt = ST_STANDBY;
            end
        endcase
        // Lockout during a charge parks it until a fresh rise
        if ((state_r == ST_ON || state_r == ST_OFF) && !supplyOk) begin
            state_nxt = ST_LOCKED;
        end
        if (state_r != ST_STANDBY && state_r != ST_SETUP && !chargeHigh) begin
            state_nxt = ST_STANDBY;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= ST_STANDBY;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || state_nxt != state_r) begin
            timer_r <= '0;
        end else if (state_r == ST_SETUP || state_r == ST_ON || state_r == ST_OFF) begin
            timer_r <= timer_r + TIMER_W'(1);
        end
    end

    // Edge count: first rise is level zero, saturates at the lowest level
    always_ff @(posedge sys_clk) begin
        if (srst || state_r == ST_STANDBY) begin
            edgeCnt_r <= LIMIT_DEFAULT;
        end else if (state_r == ST_SETUP && chargeRise && edgeCnt_r != LIMIT_LOWEST) begin
            edgeCnt_r <= edgeCnt_r + LIMIT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || state_nxt == ST_STANDBY) begin
            currentLimitCode <= LIMIT_DEFAULT;
        end else if (state_r == ST_SETUP && windowEnd) begin
            currentLimitCode <= edgeCnt_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            switchOn   <= 1'b0;
            timerMode  <= 1'b1;
            charging   <= 1'b0;
            gateDrive  <= 1'b0;
        end else begin
            switchOn   <= (state_nxt == ST_ON);
            timerMode  <= ~fastModeOk;
            charging   <= (state_nxt == ST_SETUP || state_nxt == ST_ON || state_nxt == ST_OFF);
            gateDrive  <= trigHigh;
        end
    end

    assign link.doneOut = 1'b0;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.doneOeN <= 1'b1;
        end else begin
            link.doneOeN <= ~(chargeHigh && state_nxt == ST_DONE);
        end
    end

endmodule // fcc_device

/* File: fcc_host.sv */
// Host end: drives charge request with limit pulses, and the trigger pin.
// Assumes the done line comes through the link with a pull-up.
module fcc_host
    import fcc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    fcc_link_if.hst                link,
    input  wire logic              startCharge,
    input  wire logic [fcc_pkg::LIMIT_W-1:0] limitCode,
    input  wire logic              stopCharge,
    input  wire logic              fire,
    output logic                   busy,
    output logic                   chargeDone,
    output logic                   fireTaken
);
    import fcc_pkg::*;

    // ------------------------------------------------------------
    // Done line synchroniser
    // ------------------------------------------------------------
    logic [2:0]           doneSync_r;
    logic                 doneHigh_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            doneSync_r <= 3'h7;
            doneHigh_r <= 1'b1;
        end else begin
            doneSync_r <= {doneSync_r[1:0], link.doneLine};
            if (doneSync_r[1] == doneSync_r[2]) begin
                doneHigh_r <= doneSync_r[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Charge request sequencer
    // ------------------------------------------------------------
    fcc_host_state_t      state_r;
    logic [TIMER_W-1:0]   timer_r;
    logic [LIMIT_W-1:0]   pulsesLeft_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r            <= HS_IDLE;
            timer_r            <= '0;
            pulsesLeft_r       <= '0;
            link.chargeRequest <= 1'b0;
        end else if (stopCharge) begin
            state_r            <= HS_IDLE;
            link.chargeRequest <= 1'b0;
        end else begin
            timer_r <= timer_r + TIMER_W'(1);
            unique case (state_r)
                HS_IDLE: begin
                    if (startCharge) begin
                        // Low first so the decoder restarts from scratch
                        state_r            <= HS_LOW;
                        timer_r            <= '0;
                        pulsesLeft_r       <= limitCode;
                        link.chargeRequest <= 1'b0;
                    end
                end
                HS_LOW: begin
                    if (timer_r == TIMER_W'(SHORT_PULSE_CYC - 1)) begin
                        state_r            <= HS_FIRST;
                        timer_r            <= '0;
                        link.chargeRequest <= 1'b1;
                    end
                end
                HS_FIRST: begin
                    if (timer_r == TIMER_W'(FIRST_PULSE_CYC - 1)) begin
                        timer_r <= '0;
                        if (pulsesLeft_r == '0) begin
                            state_r <= HS_HOLD;
                        end else begin
                            state_r            <= HS_GAPLOW;
                            link.chargeRequest <= 1'b0;
                        end
                    end
                end
                HS_GAPLOW: begin
                    if (timer_r == TIMER_W'(SHORT_PULSE_CYC - 1)) begin
                        state_r            <= HS_GAPHIGH;
                        timer_r            <= '0;
                        pulsesLeft_r       <= pulsesLeft_r - LIMIT_W'(1);
                        link.chargeRequest <= 1'b1;
                    end
                end
                HS_GAPHIGH: begin
                    if (timer_r == TIMER_W'(SHORT_PULSE_CYC - 1)) begin
                        timer_r <= '0;
                        if (pulsesLeft_r == '0) begin
                            state_r <= HS_HOLD;
                        end else begin
                            state_r            <= HS_GAPLOW;
                            link.chargeRequest <= 1'b0;
                        end
                    end
                end
                HS_HOLD: begin
                    timer_r <= '0;
                end
                default: begin
                    state_r            <= HS_IDLE;
                    link.chargeRequest <= 1'b0;
                end
            endcase
        end
    end

    assign busy       = (state_r != HS_IDLE);
    assign chargeDone = (state_r == HS_HOLD) & ~doneHigh_r;

    // ------------------------------------------------------------
    // Trigger pulse
    // ------------------------------------------------------------
    logic [TIMER_W-1:0]   trigCnt_r;
    logic                 fireOk;

    // Refused while a charge is still running
    assign fireOk    = (state_r == HS_IDLE) || chargeDone;
    assign fireTaken = fire & fireOk & ~link.trigger;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.trigger <= 1'b0;
            trigCnt_r    <= '0;
        end else if (fireTaken) begin
            link.trigger <= 1'b1;
            trigCnt_r    <= '0;
        end else if (link.trigger) begin
            trigCnt_r <= trigCnt_r + TIMER_W'(1);
            if (trigCnt_r == TIMER_W'(TRIGGER_IN_PULSE_CYC - 1)) begin
                link.trigger <= 1'b0;
            end
        end
    end

endmodule // fcc_host

/* File: fcc_link_sva.sv */
// Checker for the host-to-charger link signals.
// Assumes one clock, srst synchronous active high, host idle >= 100 cycles before a charge.
module fcc_link_sva
    import fcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic chargeRequest,
    input wire logic trigger,
    input wire logic doneOut,
    input wire logic doneOeN,
    input wire logic doneLine
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // Pulse length helpers
    // ----
    localparam int SEQ_IDLE = 100;
    logic [15:0] hiCnt_r;
    logic [15:0] loCnt_r;
    logic [15:0] seqCnt_r;
    logic        firstPend_r;
    logic        seqStart;

    // A rise after a long low opens a programming burst
    assign seqStart = chargeRequest && (loCnt_r >= 16'(SEQ_IDLE));

    always_ff @(posedge sys_clk) begin
        if (srst || !chargeRequest)
            hiCnt_r <= 16'h0;
        else if (hiCnt_r != 16'hffff)
            hiCnt_r <= hiCnt_r + 16'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (srst || chargeRequest)
            loCnt_r <= 16'h0;
        else if (loCnt_r != 16'hffff)
            loCnt_r <= loCnt_r + 16'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (srst || seqStart)
            seqCnt_r <= 16'h0;
        else if (seqCnt_r != 16'hffff)
            seqCnt_r <= seqCnt_r + 16'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !chargeRequest)
            firstPend_r <= 1'b0;
        else if (seqStart)
            firstPend_r <= 1'b1;
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence trigger_in_pulse_s;
        trigger [*8];
    endsequence
    sequence idle_s;
        (!chargeRequest && doneOeN) [*8];
    endsequence

    done_low_drive_a: assert property (!doneOeN |-> doneOut == 1'b0)
        else $error("done line driven high");
    done_cause_a: assert property ($fell(doneOeN) |-> $past(chargeRequest, 6))
        else $error("done pulled without request");
    done_release_a: assert property (!chargeRequest [*8] |-> doneOeN)
        else $error("done held with request low");
    power_up_idle_a: assert property ($fell(srst) |-> idle_s)
        else $error("request not low after reset");
    trigger_in_safe_a: assert property ($rose(trigger) |-> !chargeRequest || !doneLine)
        else $error("trigger during charging");
    trigger_in_pulse_a: assert property ($rose(trigger) |-> trigger_in_pulse_s)
        else $error("trigger pulse too short");
    first_pulse_a: assert property ($fell(chargeRequest) && firstPend_r |-> hiCnt_r >= FIRST_PULSE_CYC)
        else $error("first pulse too short");
    short_pulse_a: assert property ($fell(chargeRequest) |-> hiCnt_r >= SHORT_PULSE_CYC)
        else $error("later pulse too short");
    last_edge_a: assert property ($rose(chargeRequest) && !seqStart |-> seqCnt_r < SETUP_WINDOW_CYC)
        else $error("late programming edge");
endmodule // fcc_link_sva

/* File: flash_charger_control_tb.sv */
// Testbench joining host and charger ends through the link.
// Assumes a shortened setup window on the charger end.
module flash_charger_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcc_pkg::*;

    localparam int unsigned SETUP = 5000;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       supplyOk = 1'b1;
    logic       peakReached = 1'b0;
    logic       fluxReset = 1'b0;
    logic       fastModeOk = 1'b0;
    logic       targetReached = 1'b0;
    logic       startCharge = 1'b0;
    logic       stopCharge = 1'b0;
    logic       fire = 1'b0;
    logic [3:0] limitCode = 4'h0;
    logic       switchOn, gateDrive, timerMode, charging, busy, chargeDone, fireTaken;
    logic [3:0] currentLimitCode;
    int         nFail = 0;
    int         samplesChecked = 0;
    int         expQ[$];

    fcc_link_if link ();
    fcc_device #(.SETUP_CYC(SETUP)) u_fcc_device (.sys_clk(sys_clk), .srst(srst), .link(link),
        .supplyOk(supplyOk), .peakReached(peakReached), .fluxReset(fluxReset), .fastModeOk(fastModeOk),
        .targetReached(targetReached), .switchOn(switchOn), .gateDrive(gateDrive), .timerMode(timerMode),
        .charging(charging), .currentLimitCode(currentLimitCode));
    fcc_host u_fcc_host (.sys_clk(sys_clk), .srst(srst), .link(link), .startCharge(startCharge),
        .limitCode(limitCode), .stopCharge(stopCharge), .fire(fire), .busy(busy),
        .chargeDone(chargeDone), .fireTaken(fireTaken));
    fcc_link_sva u_fcc_link_sva (.sys_clk(sys_clk), .srst(srst), .chargeRequest(link.chargeRequest),
        .trigger(link.trigger), .doneOut(link.doneOut), .doneOeN(link.doneOeN), .doneLine(link.doneLine));

    always #2.5 sys_clk = ~sys_clk;

    // ----
    // Checking helpers
    // ----
    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic pick(int s);
        case (s)
            0: return charging;
            1: return switchOn;
            2: return link.doneLine;
            default: return gateDrive;
        endcase
    endfunction

    task automatic waitFor(int s, logic v, int n, string what);
        for (int j = 0; j < n && pick(s) !== v; j++) @(negedge sys_clk);
        check(what, {3'h0, v}, {3'h0, pick(s)});
    endtask

    // Samples every cycle but counts one compare, keeping the last bad value
    task automatic holds(int s, logic v, int n, string what);
        logic seen = v;
        repeat (n) begin
            @(negedge sys_clk);
            if (pick(s) !== v) seen = pick(s);
        end
        check(what, {3'h0, v}, {3'h0, seen});
    endtask

    task automatic strobe(int s);
        if (s == 0) startCharge = 1'b1; else stopCharge = 1'b1;
        @(negedge sys_clk);
        {startCharge, stopCharge} = 2'b00;
    endtask

    // Fire strobe; host takes it only when idle or done
    task automatic tryFire(logic exp);
        fire = 1'b1;
        #1;
        check("fire taken", {3'h0, exp}, {3'h0, fireTaken});
        @(negedge sys_clk);
        fire = 1'b0;
    endtask

    task automatic peak();
        peakReached = 1'b1;
        @(negedge sys_clk);
        peakReached = 1'b0;
        check("switch off at peak", 4'h0, {3'h0, switchOn});
    endtask

    task automatic fireGate();
        tryFire(1'b1);
        waitFor(3, 1'b1, 10, "gate rise");
        holds(3, 1'b1, 190, "gate high");
        waitFor(3, 1'b0, 20, "gate fall");
    endtask

    task automatic stopAll();
        strobe(1);
        waitFor(2, 1'b1, 10, "done release");
        holds(1, 1'b0, 150, "standby");
        check("decoder reset", LIMIT_DEFAULT, currentLimitCode);
        check("host idle", 4'h0, {3'h0, busy});
    endtask

    // ----
    // One full charge
    // ----
    task automatic run(logic [3:0] code, bit slow);
        int rises = code + 1;
        expQ.push_back(rises > 16 ? 15 : rises - 1);
        limitCode = code;
        strobe(0);
        waitFor(0, 1'b1, 200, "charge start");
        check("host busy", 4'h1, {3'h0, busy});
        tryFire(1'b0);
        holds(1, 1'b0, SETUP - 20, "switch in setup");
        waitFor(1, 1'b1, 60, "switch on");
        check("limit code", 4'(expQ.pop_front()), currentLimitCode);
        peak();
        if (slow) begin
            check("timer mode", 4'h1, {3'h0, timerMode});
            // Flux reset must not shorten the fixed off-time
            fluxReset = 1'b1;
            holds(1, 1'b0, 3500, "timer off");
            fluxReset = 1'b0;
            waitFor(1, 1'b1, 200, "timer restart");
            fastModeOk = 1'b1;
            peak();
        end
        fluxReset = 1'b1;
        waitFor(1, 1'b1, 8, "fast restart");
        fluxReset = 1'b0;
        check("fast mode", 4'h0, {3'h0, timerMode});
        peak();
        targetReached = 1'b1;
        waitFor(2, 1'b0, 10, "done flag");
        holds(1, 1'b0, 40, "stop at target");
        targetReached = 1'b0;
        holds(0, 1'b0, 60, "no recharge");
        check("host done", 4'h1, {3'h0, chargeDone});
        fireGate();
        stopAll();
        $display("charge test done code %0d", code);
    endtask

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        nFail++;
        giveVerdict();
    end

    initial begin
        void'($urandom(56393));
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        @(negedge sys_clk);
        check("reset limit", LIMIT_DEFAULT, currentLimitCode);
        check("reset done", 4'h1, {3'h0, link.doneLine});
        fireGate();
        $display("idle trigger test done");
        supplyOk = 1'b0;
        strobe(0);
        holds(0, 1'b0, 1800, "locked");
        supplyOk = 1'b1;
        holds(0, 1'b0, 1800, "needs fresh rise");
        stopAll();
        $display("lockout test done");
        run(4'h0, 1'b1);
        run(4'hf, 1'b0);
        run(4'($urandom_range(1, 14)), 1'b0);
        giveVerdict();
    end
endmodule // flash_charger_control_tb
